// >>> logic/fifo_irq_pkg.sv
// shared constants and helpers for the fifo interrupt aggregator
package fifo_irq_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SRC_W  = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
    localparam logic [ADDR_W-1:0] TX_LEVEL_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] RX_LEVEL_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] TX_REQ_OFS    = 8'h10;
    localparam logic [ADDR_W-1:0] TX_SET_OFS    = 8'h14;
    localparam logic [ADDR_W-1:0] TX_MASK_OFS   = 8'h18;
    localparam logic [ADDR_W-1:0] TX_MASKED_OFS = 8'h1c;
    localparam logic [ADDR_W-1:0] RX_REQ_OFS    = 8'h20;
    localparam logic [ADDR_W-1:0] RX_SET_OFS    = 8'h24;
    localparam logic [ADDR_W-1:0] RX_MASK_OFS   = 8'h28;
    localparam logic [ADDR_W-1:0] RX_MASKED_OFS = 8'h2c;

    // control fields
    localparam int CTRL_W          = 2;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_LATE_BIT   = 1;

    // source bit positions
    localparam int TX_EMPTY_BIT     = 0;
    localparam int TX_NOT_FULL_BIT  = 1;
    localparam int TX_LEVEL_BIT     = 2;
    localparam int RX_NOT_EMPTY_BIT = 0;
    localparam int RX_FULL_BIT      = 1;
    localparam int RX_LEVEL_BIT     = 2;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam logic [SRC_W-1:0]  SRC_RESET  = 3'h0;
    localparam logic [SRC_W-1:0]  MASK_RESET = 3'h0;
    localparam int                LEVEL_RESET = 0;

    // request bits that pass their mask
    function automatic logic [SRC_W-1:0] mask_view(input logic [SRC_W-1:0] src,
                                                   input logic [SRC_W-1:0] mask);
        mask_view = src & mask;
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [SRC_W-1:0] v);
        widen = '0;
        widen[SRC_W-1:0] = v;
    endfunction

endpackage

// >>> logic/irq_bank_if.sv
// signals between a condition generator, a source bank and the register file
`timescale 1ns/1ns
interface irq_bank_if;
    logic [fifo_irq_pkg::SRC_W-1:0] cond;
    logic [fifo_irq_pkg::SRC_W-1:0] clr;
    logic [fifo_irq_pkg::SRC_W-1:0] set;
    logic                           hold_clear;
    logic [fifo_irq_pkg::SRC_W-1:0] src;

    modport gen  (output cond);
    modport bank (input cond, input clr, input set, input hold_clear, output src);
    modport regs (input cond, output clr, output set, output hold_clear, input src);
endinterface

// >>> logic/fifo_level_cond.sv
// registered fifo occupancy conditions for one direction
`timescale 1ns/1ns
module fifo_level_cond #(
    parameter int DEPTH   = 8,
    parameter bit RX_SIDE = 1'b0,
    localparam int CW     = $clog2(DEPTH + 1)
) (
    input  wire logic          clock_in,
    input  wire logic          reset_n_in,
    input  wire logic [CW-1:0] count_in,
    input  wire logic [CW-1:0] level_in,
    input  wire logic          active_in,
    irq_bank_if.gen            bus
);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    logic [fifo_irq_pkg::SRC_W-1:0] cond_reg;
    logic [fifo_irq_pkg::SRC_W-1:0] cond_next;

    if (DEPTH < 2) begin : depth_check
        $error("fifo depth below two is not supported");
    end

    always_comb begin
        cond_next = '0;
        if (active_in) begin
            if (RX_SIDE) begin
                cond_next[fifo_irq_pkg::RX_NOT_EMPTY_BIT] = (count_in != '0);
                cond_next[fifo_irq_pkg::RX_FULL_BIT]      = (count_in == FULL_COUNT);
                cond_next[fifo_irq_pkg::RX_LEVEL_BIT]     = (count_in > level_in);
            end else begin
                cond_next[fifo_irq_pkg::TX_EMPTY_BIT]    = (count_in == '0);
                cond_next[fifo_irq_pkg::TX_NOT_FULL_BIT] = (count_in < FULL_COUNT);
                cond_next[fifo_irq_pkg::TX_LEVEL_BIT]    = (count_in < level_in);
            end
        end
    end

    // sampled on every rising clock edge
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            cond_reg <= fifo_irq_pkg::SRC_RESET;
        end else begin
            cond_reg <= cond_next;
        end
    end

    assign bus.cond = cond_reg;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    cond_sample_a: assert property ((active_in && count_in == '0)
        |=> (bus.cond[0] == !RX_SIDE))
        else $error("empty fifo condition not sampled");
endmodule

// >>> logic/irq_source_bank.sv
// sticky request bits for one direction
`timescale 1ns/1ns
module irq_source_bank (
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    irq_bank_if.bank  bus
);
    logic [fifo_irq_pkg::SRC_W-1:0] src_reg;
    logic [fifo_irq_pkg::SRC_W-1:0] src_next;

    always_comb begin
        if (bus.hold_clear) begin
            src_next = '0;
        end else begin
            // a clear beats the condition for one cycle, then it restores
            src_next = (src_reg & ~bus.clr) | bus.set | (bus.cond & ~bus.clr);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            src_reg <= fifo_irq_pkg::SRC_RESET;
        end else begin
            src_reg <= src_next;
        end
    end

    assign bus.src = src_reg;
endmodule

// >>> logic/fifo_interrupt_aggregator.sv
// fifo interrupt sources, masks and combined request of a serial block
`timescale 1ns/1ns
module fifo_interrupt_aggregator #(
    parameter int FIFO_DEPTH = 8,
    localparam int CW        = $clog2(FIFO_DEPTH + 1)
) (
    input  wire logic                              clock_in,
    input  wire logic                              reset_n_in,
    input  wire logic [fifo_irq_pkg::ADDR_W-1:0]   addr_in,
    input  wire logic [fifo_irq_pkg::DATA_W-1:0]   wdata_in,
    input  wire logic                              wr_in,
    input  wire logic                              rd_in,
    input  wire logic [CW-1:0]                     tx_count_in,
    input  wire logic [CW-1:0]                     rx_count_in,
    output logic      [fifo_irq_pkg::DATA_W-1:0]   rdata_out,
    output logic                                   irq_out,
    output logic                                   tx_fifo_flush_out
);
    localparam int SW = fifo_irq_pkg::SRC_W;

    // level fields and full compare need two entries at least
    if (FIFO_DEPTH < 2) begin : depth_check
        $error("fifo depth below two is not supported");
    end

    logic [fifo_irq_pkg::CTRL_W-1:0] ctrl_reg;
    logic [fifo_irq_pkg::CTRL_W-1:0] ctrl_next;
    logic [CW-1:0]                   tx_level_reg;
    logic [CW-1:0]                   tx_level_next;
    logic [CW-1:0]                   rx_level_reg;
    logic [CW-1:0]                   rx_level_next;
    logic [SW-1:0]                   tx_mask_reg;
    logic [SW-1:0]                   tx_mask_next;
    logic [SW-1:0]                   rx_mask_reg;
    logic [SW-1:0]                   rx_mask_next;
    logic [fifo_irq_pkg::DATA_W-1:0] rdata_reg;
    logic [fifo_irq_pkg::DATA_W-1:0] rdata_next;

    logic          enable;
    logic          late_variant;
    logic [CW-1:0] tx_count_eff;
    logic [SW-1:0] tx_masked;
    logic [SW-1:0] rx_masked;

    irq_bank_if tx_if ();
    irq_bank_if rx_if ();

    assign enable       = ctrl_reg[fifo_irq_pkg::CTRL_ENABLE_BIT];
    assign late_variant = ctrl_reg[fifo_irq_pkg::CTRL_LATE_BIT];

    // a disabled block flushes its tx fifo
    assign tx_fifo_flush_out = !enable;
    assign tx_count_eff      = enable ? tx_count_in : '0;

    // condition generators
    fifo_level_cond #(
        .DEPTH   (FIFO_DEPTH),
        .RX_SIDE (1'b0)
    ) tx_cond (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .count_in   (tx_count_eff),
        .level_in   (tx_level_reg),
        .active_in  (1'b1),
        .bus        (tx_if)
    );

    // disabled rx side stops new conditions, old bits stay only while the late bit is clear
    fifo_level_cond #(
        .DEPTH   (FIFO_DEPTH),
        .RX_SIDE (1'b1)
    ) rx_cond (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .count_in   (rx_count_in),
        .level_in   (rx_level_reg),
        .active_in  (enable),
        .bus        (rx_if)
    );

    irq_source_bank tx_bank (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .bus        (tx_if)
    );

    irq_source_bank rx_bank (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .bus        (rx_if)
    );

    // clear and set views of the request registers
    always_comb begin
        tx_if.clr = '0;
        tx_if.set = '0;
        rx_if.clr = '0;
        rx_if.set = '0;
        if (wr_in && addr_in == fifo_irq_pkg::TX_REQ_OFS) begin
            tx_if.clr = wdata_in[SW-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::TX_SET_OFS) begin
            tx_if.set = wdata_in[SW-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::RX_REQ_OFS) begin
            rx_if.clr = wdata_in[SW-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::RX_SET_OFS) begin
            rx_if.set = wdata_in[SW-1:0];
        end
    end

    assign tx_if.hold_clear = !enable && late_variant;
    assign rx_if.hold_clear = !enable && late_variant;

    // plain configuration registers
    always_comb begin
        ctrl_next     = ctrl_reg;
        tx_level_next = tx_level_reg;
        rx_level_next = rx_level_reg;
        tx_mask_next  = tx_mask_reg;
        rx_mask_next  = rx_mask_reg;
        if (wr_in && addr_in == fifo_irq_pkg::CTRL_OFS) begin
            ctrl_next = wdata_in[fifo_irq_pkg::CTRL_W-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::TX_LEVEL_OFS) begin
            tx_level_next = wdata_in[CW-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::RX_LEVEL_OFS) begin
            rx_level_next = wdata_in[CW-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::TX_MASK_OFS) begin
            tx_mask_next = wdata_in[SW-1:0];
        end else if (wr_in && addr_in == fifo_irq_pkg::RX_MASK_OFS) begin
            rx_mask_next = wdata_in[SW-1:0];
        end
    end

    assign tx_masked = fifo_irq_pkg::mask_view(tx_if.src, tx_mask_reg);
    assign rx_masked = fifo_irq_pkg::mask_view(rx_if.src, rx_mask_reg);

    // read mux, unmapped offsets read zero
    always_comb begin
        rdata_next = '0;
        if (!rd_in) begin
            rdata_next = '0;
        end else if (addr_in == fifo_irq_pkg::CTRL_OFS) begin
            rdata_next[fifo_irq_pkg::CTRL_W-1:0] = ctrl_reg;
        end else if (addr_in == fifo_irq_pkg::TX_LEVEL_OFS) begin
            rdata_next[CW-1:0] = tx_level_reg;
        end else if (addr_in == fifo_irq_pkg::RX_LEVEL_OFS) begin
            rdata_next[CW-1:0] = rx_level_reg;
        end else if (addr_in == fifo_irq_pkg::TX_REQ_OFS
                     || addr_in == fifo_irq_pkg::TX_SET_OFS) begin
            rdata_next = fifo_irq_pkg::widen(tx_if.src);
        end else if (addr_in == fifo_irq_pkg::RX_REQ_OFS
                     || addr_in == fifo_irq_pkg::RX_SET_OFS) begin
            rdata_next = fifo_irq_pkg::widen(rx_if.src);
        end else if (addr_in == fifo_irq_pkg::TX_MASK_OFS) begin
            rdata_next = fifo_irq_pkg::widen(tx_mask_reg);
        end else if (addr_in == fifo_irq_pkg::RX_MASK_OFS) begin
            rdata_next = fifo_irq_pkg::widen(rx_mask_reg);
        end else if (addr_in == fifo_irq_pkg::TX_MASKED_OFS) begin
            rdata_next = fifo_irq_pkg::widen(tx_masked);
        end else if (addr_in == fifo_irq_pkg::RX_MASKED_OFS) begin
            rdata_next = fifo_irq_pkg::widen(rx_masked);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            ctrl_reg     <= fifo_irq_pkg::CTRL_RESET;
            tx_level_reg <= CW'(fifo_irq_pkg::LEVEL_RESET);
            rx_level_reg <= CW'(fifo_irq_pkg::LEVEL_RESET);
            tx_mask_reg  <= fifo_irq_pkg::MASK_RESET;
            rx_mask_reg  <= fifo_irq_pkg::MASK_RESET;
            rdata_reg    <= '0;
        end else begin
            ctrl_reg     <= ctrl_next;
            tx_level_reg <= tx_level_next;
            rx_level_reg <= rx_level_next;
            tx_mask_reg  <= tx_mask_next;
            rx_mask_reg  <= rx_mask_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;

    // single request line from all enabled sources
    assign irq_out = (|tx_masked) || (|rx_masked);

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    irq_when_enabled_a: assert property (((tx_if.src & tx_mask_reg) != '0) |-> irq_out)
        else $error("enabled tx source without request");

    irq_has_cause_a: assert property (irq_out
        |-> ((tx_if.src & tx_mask_reg) | (rx_if.src & rx_mask_reg)) != '0)
        else $error("request without enabled source");

    w1c_clear_a: assert property ((wr_in && addr_in == fifo_irq_pkg::TX_REQ_OFS
        && wdata_in[0]) |=> !tx_if.src[0])
        else $error("write one did not clear tx source");

    zero_write_keep_a: assert property ((wr_in && addr_in == fifo_irq_pkg::RX_REQ_OFS
        && !wdata_in[1] && rx_if.src[1] && !rx_if.hold_clear) |=> rx_if.src[1])
        else $error("write zero changed rx source");

    restore_gap_a: assert property ((rx_if.clr[0] && rx_if.cond[0] && !rx_if.hold_clear)
        ##1 (rx_if.cond[0] && !rx_if.clr[0] && !rx_if.hold_clear)
        |-> !rx_if.src[0] ##1 rx_if.src[0])
        else $error("cleared source not restored after one cycle");

    gap_no_irq_a: assert property ((tx_if.clr == 3'h7 && rx_if.src == '0
        && rx_if.cond == '0) |=> !irq_out)
        else $error("cleared source drove request");

    tx_empty_a: assert property ((enable && tx_count_in == '0 && !tx_if.clr[0])
        ##1 (!tx_if.clr[0] && !tx_if.hold_clear) |=> tx_if.src[0])
        else $error("tx empty source not set");

    rx_full_a: assert property ((enable && rx_count_in == CW'(FIFO_DEPTH))
        ##1 (!rx_if.clr[1] && !rx_if.hold_clear) |=> rx_if.src[1])
        else $error("rx full source not set");

    tx_level_a: assert property ((enable && tx_count_in < tx_level_reg)
        ##1 (!tx_if.clr[2] && !tx_if.hold_clear) |=> tx_if.src[2])
        else $error("tx level source not set");

    rx_level_a: assert property ((enable && rx_count_in > rx_level_reg)
        ##1 (!rx_if.clr[2] && !rx_if.hold_clear) |=> rx_if.src[2])
        else $error("rx level source not set");

    early_tx_stuck_a: assert property ((!enable && !late_variant)
        ##1 (!enable && !late_variant && !tx_if.clr[0]) |=> tx_if.src[0])
        else $error("disabled early block lost tx empty");

    late_clear_all_a: assert property ((!enable && late_variant)
        |=> (tx_if.src == '0 && rx_if.src == '0))
        else $error("late disable left a source set");

    early_rx_keep_a: assert property ((!enable && !late_variant && rx_if.src[0]
        && !rx_if.clr[0]) |=> rx_if.src[0])
        else $error("early disable dropped rx source");

    masked_read_a: assert property ((rd_in && addr_in == fifo_irq_pkg::RX_MASKED_OFS)
        |=> rdata_out == fifo_irq_pkg::widen($past(rx_masked)))
        else $error("masked view wrong");

    set_view_a: assert property ((wr_in && addr_in == fifo_irq_pkg::TX_SET_OFS
        && wdata_in[1] && !tx_if.hold_clear) |=> tx_if.src[1])
        else $error("set view did not set tx source");

    // request line, read path, source setting and disabled states
    rx_irq_a: assert property (((rx_if.src & rx_mask_reg) != '0) |-> irq_out)
        else $error("enabled rx source without request");

    rdata_idle_a: assert property (!rd_in |=> rdata_out == '0)
        else $error("read data not zero outside a read");

    req_read_a: assert property ((rd_in && addr_in == fifo_irq_pkg::TX_REQ_OFS)
        |=> rdata_out == fifo_irq_pkg::widen($past(tx_if.src)))
        else $error("request view read wrong");

    tx_masked_read_a: assert property ((rd_in && addr_in == fifo_irq_pkg::TX_MASKED_OFS)
        |=> rdata_out == fifo_irq_pkg::widen($past(tx_masked)))
        else $error("tx masked view wrong");

    rx_frozen_a: assert property (!enable |=> rx_if.cond == '0)
        else $error("disabled rx side raised a condition");

    tx_not_full_a: assert property ((enable && tx_count_in < CW'(FIFO_DEPTH))
        ##1 (!tx_if.clr[1] && !tx_if.hold_clear) |=> tx_if.src[1])
        else $error("tx not full source not set");

    rx_not_empty_a: assert property ((enable && rx_count_in != '0)
        ##1 (!rx_if.clr[0] && !rx_if.hold_clear) |=> rx_if.src[0])
        else $error("rx not empty source not set");

    late_set_block_a: assert property ((!enable && late_variant && wr_in
        && addr_in == fifo_irq_pkg::TX_SET_OFS) |=> tx_if.src == '0)
        else $error("late disable let a set write through");

    restore_seen_c: cover property (rx_if.clr[0] && rx_if.cond[0]
        ##1 !rx_if.src[0] ##1 rx_if.src[0]);
    irq_rise_c: cover property (!irq_out ##1 irq_out);
    late_off_c: cover property ($fell(enable) && late_variant);
    early_off_c: cover property ($fell(enable) && !late_variant && rx_if.src != '0);
    early_back_c: cover property (!enable && tx_if.clr[0] ##1 !tx_if.src[0] ##1 tx_if.src[0]);
endmodule

// >>> dv/irq_ctrl_model.sv
// processor interrupt controller seen from the serial block
`timescale 1ns/1ns
module irq_ctrl_model (
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    input  wire logic irq_in,
    input  wire logic ack_in,
    output logic      pending_out,
    output int        req_count_out
);
    logic irq_prev_reg;

    // latch the level request until the handler acknowledges it
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            pending_out   <= 1'b0;
            irq_prev_reg  <= 1'b0;
            req_count_out <= 0;
        end else begin
            irq_prev_reg <= irq_in;
            if (irq_in && !irq_prev_reg) begin
                req_count_out <= req_count_out + 1;
            end
            if (irq_in) begin
                pending_out <= 1'b1;
            end else if (ack_in) begin
                pending_out <= 1'b0;
            end
        end
    end
endmodule

// >>> dv/tb.sv
// self-checking bench for the fifo interrupt aggregator
`timescale 1ns/1ns
module tb;
    localparam int DEPTH = 8;
    localparam int CW    = $clog2(DEPTH + 1);
    logic                            clock_in;
    logic                            reset_n_in;
    logic [fifo_irq_pkg::ADDR_W-1:0] addr_in;
    logic [fifo_irq_pkg::DATA_W-1:0] wdata_in;
    logic                            wr_in;
    logic                            rd_in;
    logic [CW-1:0]                   tx_count_in;
    logic [CW-1:0]                   rx_count_in;
    logic [fifo_irq_pkg::DATA_W-1:0] rdata_out;
    logic                            irq_out;
    logic                            tx_fifo_flush_out;
    logic                            ack;
    logic                            pending;
    int                              req_count;
    int                              fail_count;
    int                              n_checks;
    int                              cycles;

    fifo_interrupt_aggregator #(.FIFO_DEPTH(DEPTH)) uut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .tx_count_in(tx_count_in), .rx_count_in(rx_count_in), .rdata_out(rdata_out),
        .irq_out(irq_out), .tx_fifo_flush_out(tx_fifo_flush_out)
    );

    irq_ctrl_model host (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .irq_in(irq_out),
        .ack_in(ack), .pending_out(pending), .req_count_out(req_count)
    );

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            stop_test;
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        chk_word(rdata_out, exp);
    endtask

    task automatic settle;
        repeat (3) @(posedge clock_in);
    endtask

    task automatic irq_is(input logic e);
        @(negedge clock_in);
        chk_bit(irq_out, e);
    endtask

    task automatic reset_state;
        settle;
        rd_chk(fifo_irq_pkg::CTRL_OFS, 32'h0000_0000);
        rd_chk(fifo_irq_pkg::TX_LEVEL_OFS, 32'h0000_0000);
        rd_chk(fifo_irq_pkg::TX_MASK_OFS, 32'h0000_0000);
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0000);
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0003);
        rd_chk(fifo_irq_pkg::TX_MASKED_OFS, 32'h0000_0000);
        rd_chk(8'h3c, 32'h0000_0000);
        irq_is(1'b0);
        chk_bit(tx_fifo_flush_out, 1'b1);
    endtask

    task automatic tx_sources;
        wr(fifo_irq_pkg::CTRL_OFS, 32'h0000_0001);
        wr(fifo_irq_pkg::TX_LEVEL_OFS, 32'h0000_0004);
        tx_count_in <= 4'h3;
        settle;
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0006);
        rd_chk(fifo_irq_pkg::TX_SET_OFS, 32'h0000_0006);
        chk_bit(tx_fifo_flush_out, 1'b0);
    endtask

    task automatic restore_irq;
        wr(fifo_irq_pkg::TX_MASK_OFS, 32'h0000_0002);
        irq_is(1'b1);
        rd_chk(fifo_irq_pkg::TX_MASKED_OFS, 32'h0000_0002);
        chk_bit(pending, 1'b1);
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0000);
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0006);
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0002);
        irq_is(1'b0);
        irq_is(1'b1);
        @(posedge clock_in);
        tx_count_in <= 4'h4;
        settle;
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0002);
        tx_count_in <= 4'h8;
        settle;
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0000);
        irq_is(1'b0);
        @(posedge clock_in);
        ack <= 1'b1;
        @(posedge clock_in);
        ack <= 1'b0;
        @(negedge clock_in);
        chk_bit(pending, 1'b0);
        chk_word(req_count, 32'h0000_0003);
    endtask

    task automatic rx_sources;
        wr(fifo_irq_pkg::RX_LEVEL_OFS, 32'h0000_0002);
        wr(fifo_irq_pkg::RX_MASK_OFS, 32'h0000_0004);
        rx_count_in <= 4'h2;
        settle;
        wr(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0001);
        irq_is(1'b0);
        @(posedge clock_in);
        rx_count_in <= 4'h3;
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0005);
        irq_is(1'b1);
        rd_chk(fifo_irq_pkg::RX_MASKED_OFS, 32'h0000_0004);
        rx_count_in <= 4'h8;
        settle;
        rx_count_in <= 4'h0;
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0007);
        wr(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0000);
        irq_is(1'b0);
    endtask

    task automatic set_view;
        wr(fifo_irq_pkg::TX_SET_OFS, 32'h0000_0004);
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0004);
        wr(fifo_irq_pkg::TX_MASK_OFS, 32'h0000_0004);
        irq_is(1'b1);
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0004);
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0000);
    endtask

    task automatic early_disable;
        @(posedge clock_in);
        rx_count_in <= 4'h3;
        settle;
        wr(fifo_irq_pkg::TX_MASK_OFS, 32'h0000_0000);
        wr(fifo_irq_pkg::CTRL_OFS, 32'h0000_0000);
        rx_count_in <= 4'h0;
        settle;
        chk_bit(tx_fifo_flush_out, 1'b1);
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0007);
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0005);
        wr(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0000);
    endtask

    task automatic late_disable;
        wr(fifo_irq_pkg::CTRL_OFS, 32'h0000_0003);
        rx_count_in <= 4'h3;
        wr(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0007);
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0005);
        irq_is(1'b1);
        wr(fifo_irq_pkg::CTRL_OFS, 32'h0000_0002);
        settle;
        rd_chk(fifo_irq_pkg::RX_REQ_OFS, 32'h0000_0000);
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0000);
        wr(fifo_irq_pkg::TX_SET_OFS, 32'h0000_0007);
        rd_chk(fifo_irq_pkg::TX_REQ_OFS, 32'h0000_0000);
        irq_is(1'b0);
        chk_bit(tx_fifo_flush_out, 1'b1);
    endtask

    initial begin
        reset_n_in  = 1'b0;
        addr_in     = 8'h00;
        wdata_in    = 32'h0000_0000;
        wr_in       = 1'b0;
        rd_in       = 1'b0;
        tx_count_in = 4'h0;
        rx_count_in = 4'h0;
        ack         = 1'b0;
        fail_count  = 0;
        n_checks    = 0;
        cycles      = 0;
        repeat (3) @(posedge clock_in);
        reset_n_in <= 1'b1;
        reset_state;
        tx_sources;
        restore_irq;
        rx_sources;
        set_view;
        early_disable;
        late_disable;
        stop_test;
    end
endmodule
